// >>> logic/drb_params.svh
// Constants for the double row buffer: geometry, reset values, counts.
// Assumes nothing; included by bare name from the package and the design.
`ifndef DRB_PARAMS_SVH
`define DRB_PARAMS_SVH
`define DRB_DATA_W 8
`define DRB_ADDR_W 8
`define DRB_DEPTH 135
`define DRB_LAST_POS 8'h86
`define DRB_ADDR_RST 8'h00
`define DRB_FLOAT_EDGES 2'h2
`define DRB_FLOAT_RST 2'h0
`define DRB_PINS_W 16
// Swap, pointer-clear and drive-off rest high so reset causes no swap
`define DRB_PINS_RST 16'h0007
`define DRB_BYTE_RST 8'h00
`endif

// >>> logic/drb_pkg.sv
// Types for the double row buffer.
// Assumes drb_params.svh is on the include path.
`include "drb_params.svh"
package drb_pkg;
   typedef logic [`DRB_DATA_W-1:0] drb_byte_t;
   typedef logic [`DRB_ADDR_W-1:0] drb_addr_t;
   typedef enum logic {DRB_BANK_0, DRB_BANK_1} drb_bank_e;
   // All pins from the far side, sampled as one word
   typedef struct packed {
      logic fillClk;
      logic drainClk;
      drb_byte_t rowIn;
      logic fillEnableA;
      logic fillEnableB;
      logic drainEnable;
      logic pointerClear;
      logic bufferSwap;
      logic outEnableN;
   } drb_pins_s;
endpackage : drb_pkg

// >>> logic/drb_double_row_buffer.sv
// Double row buffer: two 135-byte banks, one filled while the other drains.
// Assumes fill and drain clocks arrive as slow pins far below clk; every pin
// passes a two-stage synchroniser and clock edges are found on clk.
// Overview of operation
// [R1] Two banks of 135 bytes, fill and drain
// [R2] Fill clock edge captures row input byte
// [R3] Both enables high: store latch, advance counter
// [R4] Stop storing after last position or enable low
// [R5] Swap and clear both low: zero, exchange
// [R6] Drain enable reads byte, advances drain counter
// [R7] Controller holds drain enable over visible line
// [R8] Pointer-clear falling edge zeroes drain counter
// [R9] Pointer-clear may be tied to drain enable
// [R10] Last flags cascade into next device's enables
// [R11] One fill edge between clear/swap and enable
// [R12] Drain enable on drain, fill enables fill
// [R13] Flags change only on their own clocks; the code also clears fill-last on a swap's drain edge
// [R14] Fill-last flag high at last write, blocks
// [R15] Drain-last blocks reads; float after two edges
// [R16] Output valid two drain periods after enable
// [R17] Drive output only while drive-off input low
// [R18] Bank ownership swaps atomically between both sides
`timescale 1ns/1ps
`default_nettype none
`include "drb_params.svh"
module drb_double_row_buffer (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Pins from host memory and display controller
   input wire drb_pkg::drb_pins_s pinsIn,
   // Row output bus, three-state as data and enable
   output logic [`DRB_DATA_W-1:0] rowOut,
   output logic rowOutOe,
   // Cascade flags
   output logic fillLastFlag,
   output logic drainLastFlag
);
   import drb_pkg::*;

   function automatic logic drb_is_last(input drb_addr_t addr);
      return addr == `DRB_LAST_POS;
   endfunction : drb_is_last

   // Synchroniser: stage A feeds only stage B
   // Each pin phase must last several clk; a shorter pulse may be missed,
   // which is the price of running both far-side clocks off the one clk
   drb_pins_s syncA_q;
   drb_pins_s pins_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         syncA_q <= `DRB_PINS_RST;
         pins_q <= `DRB_PINS_RST;
      end else begin
         syncA_q <= pinsIn;
         pins_q <= syncA_q;
      end
   end

   // Previous values start at the idle pin levels, so no false edge follows reset
   logic fillClkPrev_q;
   logic drainClkPrev_q;
   logic ptrClearPrev_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fillClkPrev_q <= 1'b0;
         drainClkPrev_q <= 1'b0;
         ptrClearPrev_q <= 1'b1;
      end else begin
         fillClkPrev_q <= pins_q.fillClk;
         drainClkPrev_q <= pins_q.drainClk;
         ptrClearPrev_q <= pins_q.pointerClear;
      end
   end

   drb_byte_t bankMem [0:1][0:`DRB_DEPTH-1]; // R1
   drb_bank_e fillBank_q;
   drb_addr_t fillAddr_q;
   drb_addr_t drainAddr_q;
   drb_byte_t inLatch_q;
   drb_byte_t stage_q;
   drb_byte_t rowOut_q;
   logic fillDone_q;
   logic drainDone_q;
   logic fillLast_q;
   logic drainLast_q;
   logic clrPend_q;
   logic [1:0] floatCnt_q;
   logic rowOutOe_q;

   wire fillEdge = pins_q.fillClk & ~fillClkPrev_q;
   wire drainEdge = pins_q.drainClk & ~drainClkPrev_q;
   wire drb_bank_e drainBank = drb_bank_e'(~fillBank_q);
   // Enables are looked at only on their own clock's edge
   wire fillBoth = pins_q.fillEnableA & pins_q.fillEnableB; // R12
   wire fillWrite = fillEdge & fillBoth & ~fillDone_q; // R3 R4
   wire fillAtLast = drb_is_last(fillAddr_q);
   // Drain edge priority: swap, then pointer clear, then read
   wire swapNow = drainEdge & ~pins_q.bufferSwap & ~pins_q.pointerClear; // R5
   wire ptrFall = ptrClearPrev_q & ~pins_q.pointerClear; // R8
   wire drainClear = swapNow | (drainEdge & (clrPend_q | ptrFall)); // R8 R9
   wire drainRead = drainEdge & pins_q.drainEnable & ~drainDone_q & ~drainClear; // R6 R12
   wire drainAtLast = drb_is_last(drainAddr_q);
   wire fillLastD = swapNow ? 1'b0 :
                    fillEdge ? (fillDone_q | (fillWrite & fillAtLast)) : fillLast_q; // R13 R14
   wire drainLastD = drainClear ? 1'b0 :
                     drainEdge ? (drainDone_q | (drainRead & drainAtLast)) : drainLast_q; // R13
   // Float count stops at two so the bus stays off until a clear or swap
   wire floatStep = drainEdge & drainLast_q & (floatCnt_q != `DRB_FLOAT_EDGES);
   wire [1:0] floatCntD = drainClear ? `DRB_FLOAT_RST :
                          floatStep ? 2'(floatCnt_q + 2'h1) : floatCnt_q; // R15
   wire oeD = ~pins_q.outEnableN & (floatCntD != `DRB_FLOAT_EDGES); // R15 R17

   // Banks hold data only; no reset so they map onto plain storage
   always_ff @(posedge clk) begin
      if (fillWrite) begin
         bankMem[fillBank_q][fillAddr_q] <= inLatch_q; // R3
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         inLatch_q <= `DRB_BYTE_RST;
      end else if (fillEdge) begin
         inLatch_q <= pins_q.rowIn; // R2
      end
   end

   // Swap and both counters move on the same clk, so neither side ever
   // sees a half-switched bank
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fillBank_q <= DRB_BANK_0;
         fillAddr_q <= `DRB_ADDR_RST;
         fillDone_q <= 1'b0;
      end else if (swapNow) begin
         fillBank_q <= drainBank; // R5 R18
         fillAddr_q <= `DRB_ADDR_RST;
         fillDone_q <= 1'b0;
      end else if (fillWrite) begin
         if (fillAtLast) begin
            fillDone_q <= 1'b1; // R4 R14
         end else begin
            fillAddr_q <= 8'(fillAddr_q + 8'h01); // R3
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         drainAddr_q <= `DRB_ADDR_RST;
         drainDone_q <= 1'b0;
      end else if (drainClear) begin
         drainAddr_q <= `DRB_ADDR_RST; // R5 R8
         drainDone_q <= 1'b0;
      end else if (drainRead) begin
         if (drainAtLast) begin
            drainDone_q <= 1'b1; // R15
         end else begin
            drainAddr_q <= 8'(drainAddr_q + 8'h01); // R6
         end
      end
   end

   // A fall seen between drain edges waits for the next one; a new fall wins
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         clrPend_q <= 1'b0;
      end else if (ptrFall) begin
         clrPend_q <= ~drainEdge; // R8
      end else if (drainEdge) begin
         clrPend_q <= 1'b0;
      end
   end

   // Two-stage pipeline toward the character generator
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         stage_q <= `DRB_BYTE_RST;
         rowOut_q <= `DRB_BYTE_RST;
      end else if (drainEdge) begin
         if (drainRead) begin
            stage_q <= bankMem[drainBank][drainAddr_q]; // R6
         end
         rowOut_q <= stage_q; // R16
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fillLast_q <= 1'b0;
         drainLast_q <= 1'b0;
         floatCnt_q <= `DRB_FLOAT_RST;
         rowOutOe_q <= 1'b0;
      end else begin
         fillLast_q <= fillLastD; // R10 R14
         drainLast_q <= drainLastD; // R10
         floatCnt_q <= floatCntD;
         rowOutOe_q <= oeD; // R17
      end
   end

   assign rowOut = rowOut_q;
   assign rowOutOe = rowOutOe_q;
   assign fillLastFlag = fillLast_q;
   assign drainLastFlag = drainLast_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   latch_capture_a: assert property ( // R2
      fillEdge |=> inLatch_q == $past(pins_q.rowIn))
      else $error("Input latch missed the byte on a fill edge");
   fill_advance_a: assert property ( // R3
      fillWrite && !swapNow && !fillAtLast |=> fillAddr_q == $past(fillAddr_q) + 8'h01)
      else $error("Fill counter did not advance on a write");
   fill_blocked_a: assert property ( // R4
      fillDone_q && !swapNow |=> $stable(fillAddr_q) && fillDone_q)
      else $error("Fill counter moved after the last position");
   swap_exchange_a: assert property ( // R5
      swapNow |=> fillAddr_q == 8'h00 && drainAddr_q == 8'h00
                  && fillBank_q != $past(fillBank_q))
      else $error("Swap did not zero counters and exchange banks");
   drain_advance_a: assert property ( // R6
      drainRead && !drainAtLast |=> drainAddr_q == $past(drainAddr_q) + 8'h01)
      else $error("Drain counter did not advance on a read");
   ptr_clear_a: assert property ( // R8
      drainEdge && clrPend_q |=> drainAddr_q == 8'h00 && !drainDone_q)
      else $error("Pending pointer clear did not zero the drain counter");
   flag_sync_a: assert property ( // R13
      $changed(drainLast_q) |-> $past(drainEdge))
      else $error("Drain-last flag changed off a drain edge");
   fill_flag_sync_a: assert property ( // R13
      $changed(fillLast_q) |-> $past(fillEdge) || $past(swapNow))
      else $error("Fill-last flag changed off a fill edge or swap");
   fill_last_a: assert property ( // R14
      fillWrite && fillAtLast && !swapNow |=> fillLast_q && fillDone_q)
      else $error("Fill-last flag not raised on the last write");
   float_after_a: assert property ( // R15
      drainLast_q && drainEdge && floatCnt_q == 2'h1 && !drainClear |=> ##1 !rowOutOe_q)
      else $error("Output not floated on second edge after drain-last");
   pipe_delay_a: assert property ( // R16
      drainEdge |=> rowOut_q == $past(stage_q))
      else $error("Staged byte did not reach the output on a drain edge");
   drive_off_a: assert property ( // R17
      pins_q.outEnableN |=> !rowOutOe_q)
      else $error("Output driven while drive-off input is high");

   // Nothing moves between the edges that own it
   latch_hold_a: assert property ( // R2
      !fillEdge |=> $stable(inLatch_q))
      else $error("Input latch changed off a fill edge");
   fill_hold_a: assert property ( // R3
      !fillWrite && !swapNow |=> $stable(fillAddr_q))
      else $error("Fill counter moved without a write or swap");
   drain_hold_a: assert property ( // R6
      !drainRead && !drainClear |=> $stable(drainAddr_q))
      else $error("Drain counter moved without a read or clear");
   out_hold_a: assert property ( // R16
      !drainEdge |=> $stable(rowOut_q) && $stable(stage_q))
      else $error("Output pipeline moved off a drain edge");
   bank_hold_a: assert property ( // R18
      !swapNow |=> $stable(fillBank_q))
      else $error("Bank ownership changed without a swap");

   // Flags, counters and bus after reads, swaps and clears
   swap_flags_a: assert property ( // R5
      swapNow |=> !fillLast_q && !drainLast_q && !fillDone_q && !drainDone_q)
      else $error("Swap left a last flag or done bit set");
   clear_no_read_a: assert property ( // R8
      drainClear |=> $stable(stage_q))
      else $error("Drain edge with a clear also read a byte");
   ptr_pend_a: assert property ( // R8
      ptrFall && !drainEdge |=> clrPend_q)
      else $error("Pointer clear fall between drain edges was lost");
   pend_drop_a: assert property ( // R8
      drainEdge && !ptrFall |=> !clrPend_q)
      else $error("Pending pointer clear outlived a drain edge");
   drain_last_a: assert property ( // R15
      drainRead && drainAtLast |=> drainLast_q && drainDone_q)
      else $error("Drain-last flag not raised on the last read");
   drain_blocked_a: assert property ( // R15
      drainDone_q && !drainClear |=> $stable(drainAddr_q) && $stable(stage_q))
      else $error("Read went on after the last position");
   fill_flag_hold_a: assert property ( // R14
      fillLast_q && !swapNow |=> fillLast_q)
      else $error("Fill-last flag dropped before a swap");
   drain_flag_hold_a: assert property ( // R15
      drainLast_q && !drainClear |=> drainLast_q)
      else $error("Drain-last flag dropped before a clear");
   drive_on_a: assert property ( // R17
      !pins_q.outEnableN && !drainLast_q |=> rowOutOe_q)
      else $error("Output not driven while drive-off input is low");
   float_stays_a: assert property ( // R15
      floatCnt_q == 2'h2 && !drainClear |=> !rowOutOe_q)
      else $error("Output bus came back on before a clear or swap");

   swap_seen_c: cover property (swapNow ##[1:300] fillWrite);
   fill_full_c: cover property (fillWrite && fillAtLast);
   drain_full_c: cover property (drainRead && drainAtLast ##[1:300] !rowOutOe_q);
   tied_clear_c: cover property (ptrFall && !pins_q.drainEnable);
   fill_during_drain_c: cover property (fillWrite ##[0:7] drainRead);
endmodule : drb_double_row_buffer
`default_nettype wire

// >>> verification/drb_crt_model.sv
// Display-side controller model: drain clock bursts, line enable, row swap.
// Assumes one bench process calls its tasks, each entered after a clk edge.
`timescale 1ns/1ps
`default_nettype none
module drb_crt_model (
   // Clock
   input wire logic clk,
   // Display-side pins
   output var logic drainClk,
   output var logic drainEnable,
   output var logic pointerClear,
   output var logic bufferSwap
);
   initial begin
      drainClk = 1'b0;
      drainEnable = 1'b0;
      pointerClear = 1'b1;
      bufferSwap = 1'b1;
   end
   // Clock stands low between bursts; 32 ns period
   task automatic tick();
      @(posedge clk);
      drainClk <= 1'b1;
      repeat (4) @(posedge clk);
      drainClk <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask : tick
   // Enable and clear are driven together here, high over the visible line
   task automatic line(input logic on);
      @(posedge clk);
      drainEnable <= on;
      pointerClear <= on;
   endtask : line
   task automatic swapRow();
      @(posedge clk);
      bufferSwap <= 1'b0;
      pointerClear <= 1'b0;
      drainEnable <= 1'b0;
      tick();
      @(posedge clk);
      bufferSwap <= 1'b1;
      pointerClear <= 1'b1;
   endtask : swapRow
endmodule : drb_crt_model
`default_nettype wire

// >>> verification/testbench.sv
// Bench: fills a bank, swaps, drains it while filling the other, replays, swaps.
// Assumes drb_crt_model drives the display pins; the bench is the host.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import drb_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic fillClk = 1'b0;
   logic fillEnA = 1'b0;
   logic fillEnB = 1'b0;
   logic outEnableN = 1'b0;
   drb_byte_t rowIn = 8'h00;
   logic drainClk, drainEnable, pointerClear, bufferSwap;
   logic rowOutOe, fillLastFlag, drainLastFlag;
   drb_pins_s pins;
   drb_byte_t rowOut;
   drb_byte_t stored[2][0:134];
   int nStored[2] = '{0, 0};
   int nMismatch = 0;
   int nTests = 0;
   always #2 clk = ~clk;
   assign pins = {fillClk, drainClk, rowIn, fillEnA, fillEnB, drainEnable, pointerClear,
                  bufferSwap, outEnableN};
   drb_double_row_buffer dut (.clk(clk), .reset(reset), .pinsIn(pins), .rowOut(rowOut),
      .rowOutOe(rowOutOe), .fillLastFlag(fillLastFlag), .drainLastFlag(drainLastFlag));
   drb_crt_model ctl (.clk(clk), .drainClk(drainClk), .drainEnable(drainEnable),
      .pointerClear(pointerClear), .bufferSwap(bufferSwap));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      nTests++;
      if (seen !== exp) begin
         nMismatch++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic conclude();
      if (nMismatch == 0 && nTests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : conclude
   task automatic fillEdge(input drb_byte_t v, input logic enA, input logic enB);
      @(posedge clk);
      rowIn <= v;
      fillEnA <= enA;
      fillEnB <= enB;
      fillClk <= 1'b1;
      repeat (4) @(posedge clk);
      fillClk <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask : fillEdge
   // First edge has enables low so the latch is primed; one edge drops B
   task automatic fillRow(input drb_byte_t salt, input int bank);
      logic enA;
      logic enB;
      for (int k = 0; k < 140; k++) begin
         enA = (k != 0);
         enB = (k != 0) && (k != 10);
         fillEdge(drb_byte_t'(k) ^ salt, enA, enB);
         if (enA && enB && nStored[bank] < 135) begin
            stored[bank][nStored[bank]] = drb_byte_t'(k - 1) ^ salt;
            nStored[bank]++;
         end
         chk(fillLastFlag, nStored[bank] == 135);
      end
   endtask : fillRow
   // Bytes show two drain edges late; bus floats two edges after the last read
   task automatic drainRow(input int offAt, input int bank);
      ctl.line(1'b1);
      for (int n = 1; n <= 137; n++) begin
         fork
            ctl.tick();
            begin
               @(posedge clk);
               outEnableN <= (n == offAt);
            end
         join
         chk(drainLastFlag, n >= 135);
         if (n >= 2) begin
            chk(rowOutOe, n != offAt && n <= 136);
         end
         if (n >= 2 && n <= 136 && n != offAt) begin
            chk(rowOut, stored[bank][n - 2]);
         end
      end
   endtask : drainRow
   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk(rowOutOe, 1'b1);
      chk(fillLastFlag, 1'b0);
      fillRow(8'h5A, 0);
      ctl.swapRow();
      repeat (4) @(posedge clk);
      #1;
      chk(fillLastFlag, 1'b0);
      // The next row fills the other bank while this one drains
      fork
         drainRow(50, 0);
         fillRow(8'hA5, 1);
      join
      // Clear held low over several edges still restarts from the first byte
      ctl.line(1'b0);
      repeat (3) ctl.tick();
      chk(drainLastFlag, 1'b0);
      drainRow(0, 0);
      ctl.swapRow();
      repeat (4) @(posedge clk);
      #1;
      chk(fillLastFlag, 1'b0);
      drainRow(0, 1);
      conclude();
   end
   initial begin
      repeat (30000) @(posedge clk);
      nMismatch++;
      conclude();
   end
endmodule : testbench
`default_nettype wire
